// ==== pkg/hrs_map.svh ====
// Timing counts and fixed values of the hardware reset sequencer.
// Assumes sys_clk is the CPU clock; one CPU clock period is two half-clock units.
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH
// Half-clock units per CPU clock period.
`define HRS_UNITS_PER_CLK 2
// Least low time of the reset input for synchronous detection, in half-clock units.
`define HRS_MIN_PULSE_UNITS 4
// Longest internal synchronisation window, in half-clock units.
`define HRS_SYNC_UNITS 12
// Internal reset sequence length, in half-clock units.
`define HRS_SEQ_UNITS 1024
// Pulse width above which a reset counts as long, in half-clock units.
`define HRS_LONG_UNITS 1040
// Reset input rise to configuration latch, in half-clock units.
`define HRS_LATCH_UNITS 8
// Same delay with the PLL bypassed and the prescaler active.
`define HRS_LATCH_BYP_UNITS 6
// Bidirectional-reset enable bit position in the system configuration word.
`define HRS_BDR_BIT 3
// First fetch address after reset.
`define HRS_START_ADDR 24'h000000
`endif

// ==== pkg/hrs_pkg.sv ====
// Types shared by the hardware reset sequencer.
// Assumes the timing constants come from hrs_map.svh.
package hrs_pkg;
    // Sequencer states.
    typedef enum logic [2:0] {
        HRS_RUN,
        HRS_DETECT,
        HRS_SEQ,
        HRS_EXTEND,
        HRS_LATCH,
        HRS_INIT
    } hrs_state_t;

    // Reset kind flags shown to the core.
    typedef struct packed {
        logic longReset;
        logic shortReset;
        logic asyncReset;
    } hrs_kind_t;

    // Controls that the sequencer drives into the core.
    typedef struct packed {
        logic coreReset;
        logic cancelHold;
        logic abortBus;
        logic tristateIo;
        logic pullConfigHigh;
        logic strobesIdle;
    } hrs_ctrl_t;
endpackage

// ==== logic/hrs_sync.sv ====
// Two-flip-flop synchroniser bank for pin levels entering the sys_clk domain.
// Assumes inputs are asynchronous levels; only the second stage is read outside.
`timescale 1ns/10ps
module hrs_sync #(
    parameter int WIDTH = 2 // Number of levels synchronised.
) (
    input wire logic sys_clk, // CPU clock.
    input wire logic reset_n, // Synchronous active-low reset.
    input wire logic [WIDTH-1:0] asyncIn, // Raw pin levels.
    output logic [WIDTH-1:0] syncOut // Levels after two flops.
);
    logic [WIDTH-1:0] stage1_q; // First stage, read only by the second.

    // Both stages reset high, the idle level of the reset input.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    stage1_q[i] <= 1'b1;
                    syncOut[i] <= 1'b1;
                end else begin
                    stage1_q[i] <= asyncIn[i];
                    syncOut[i] <= stage1_q[i];
                end
            end
        end
    endgenerate
endmodule

// ==== logic/hrs_top.sv ====
// Hardware reset sequencer: detects pin resets, times the internal sequence,
// drives the bidirectional pull-down and reset output, latches start-up config.
// Assumes sys_clk is the CPU clock and reset_n is the power-on reset.
// How it works
// - Low reset input forces reset default state
// - Low pulse over 1040 units is long
// - Delay level low means async, high sync
// - Delay level drop releases pull-down, async
// - Async entry still waits for the clock
// - Sync: tristate, output low, settle within twelve
// - Pull-down active only if enable bit set
// - Enable bit cleared at power-on, sequence end
// - Sequence lasts 1024 units, then sample input
// - Still low at end extends, becomes long
// - Exit async or sync by delay level
// - Latch config 8 units after rise, 6 bypassed
// - External fetch strobes idle at latch time
// - Execution starts at address zero, segment zero
// - Short pulse with level high is warm reset
// - Reset output held until end-of-init done
// - Enable bit settable only before end-of-init
`timescale 1ns/10ps
`include "hrs_map.svh"
module hrs_top import hrs_pkg::*; #(
    parameter int CFG_WIDTH = 16 // Width of the configuration port.
) (
    input wire logic sys_clk, // CPU clock, 10 MHz.
    input wire logic reset_n, // Synchronous active-low power-on reset.
    input wire logic resetInPin, // Reset pin level as seen at the pad.
    output logic resetInOut, // Reset pin output value, always low.
    output logic resetInOe, // Reset pin pull-down enable, high while pulling.
    input wire logic powerdownDelayLevel, // Delay pin comparator, high above threshold.
    input wire logic [CFG_WIDTH-1:0] configPort, // Configuration port levels.
    input wire logic pllBypass, // High when PLL bypassed with prescaler active.
    input wire logic externalFetch, // High when configured for external fetch.
    input wire logic bidirEnableSet, // One-cycle request to set the enable bit.
    input wire logic endOfInitInstr, // One-cycle pulse when end-of-init completes.
    output logic reset_out_n, // Reset output, active low.
    output hrs_ctrl_t ctrl, // Core controls during reset.
    output hrs_kind_t kind, // Kind of the last pin reset.
    output logic bidirResetEnable, // Bidirectional-reset enable bit.
    output logic [CFG_WIDTH-1:0] latchedConfig, // Latched start-up configuration.
    output logic configValid, // High once configuration is latched.
    output logic [23:0] startAddr, // First fetch address.
    output logic startFetch // One-cycle pulse: begin execution.
);
    // Cycle counts derived from half-clock units.
    localparam int MIN_CLKS = `HRS_MIN_PULSE_UNITS / `HRS_UNITS_PER_CLK;
    localparam int SYNC_CLKS = `HRS_SYNC_UNITS / `HRS_UNITS_PER_CLK;
    localparam int SEQ_CLKS = `HRS_SEQ_UNITS / `HRS_UNITS_PER_CLK;
    localparam int LONG_CLKS = `HRS_LONG_UNITS / `HRS_UNITS_PER_CLK;
    localparam int LATCH_CLKS = `HRS_LATCH_UNITS / `HRS_UNITS_PER_CLK;
    localparam int LATCH_BYP_CLKS = `HRS_LATCH_BYP_UNITS / `HRS_UNITS_PER_CLK;

    hrs_state_t state_q; // Sequencer state.
    logic [10:0] seqCnt_q; // Counts cycles inside the sequence.
    logic [10:0] pulseCnt_q; // Counts cycles the reset input stays low.
    logic [2:0] latchCnt_q; // Counts cycles from rise to latch.
    logic asyncMode_q; // Sequence will finish asynchronously.
    logic pullDown_q; // Pull-down engaged for this sequence.
    logic [1:0] pullEcho_q; // Pull-down level still in flight through the synchroniser.
    logic [1:0] syncLevels; // Synchronised reset input and delay level.
    logic rstLow; // Synchronised reset input is low.
    logic rpdHigh; // Synchronised delay level is high.
    logic rawEntry; // Unsynchronised entry for the clockless case.

    // Both pins pass two flops before counting and sampling.
    hrs_sync #(.WIDTH(2)) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .asyncIn({resetInPin, powerdownDelayLevel}),
        .syncOut(syncLevels)
    );
    assign rstLow = ~syncLevels[1];
    assign rpdHigh = syncLevels[0];

    // With both pins low rawEntry goes high straight from the pads, but it
    // drives only unusedRaw, so entry still waits for the synchroniser. Glitch-prone
    // by nature, which is accepted since the board holds them low at power-on.
    assign rawEntry = ~resetInPin & ~powerdownDelayLevel;

    // Main sequencer.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= HRS_SEQ; // Power-on runs a full asynchronous sequence.
            seqCnt_q <= 11'h000;
            asyncMode_q <= 1'b1;
            latchCnt_q <= 3'h0;
        end else begin
            case (state_q)
                HRS_RUN, HRS_INIT: begin
                    // Low for the minimum time is taken as a reset request.
                    if (rstLow && pulseCnt_q >= 11'(MIN_CLKS - 1)) begin
                        state_q <= HRS_DETECT;
                        seqCnt_q <= 11'h000;
                        asyncMode_q <= ~rpdHigh;
                    end
                end
                HRS_DETECT: begin
                    // Internal accesses settle inside the sync window.
                    seqCnt_q <= seqCnt_q + 11'h001;
                    if (seqCnt_q == 11'(SYNC_CLKS - 1)) begin
                        state_q <= HRS_SEQ;
                        seqCnt_q <= 11'h000;
                    end
                end
                HRS_SEQ: begin
                    seqCnt_q <= seqCnt_q + 11'h001;
                    if (rstLow && !rpdHigh) begin
                        asyncMode_q <= 1'b1;
                    end
                    if (seqCnt_q == 11'(SEQ_CLKS - 1)) begin
                        state_q <= rstLow ? HRS_EXTEND : HRS_LATCH;
                        asyncMode_q <= ~rpdHigh;
                        latchCnt_q <= 3'h0;
                    end
                end
                HRS_EXTEND: begin
                    // Held until the input rises; exit kind follows the delay level.
                    if (!rstLow) begin
                        state_q <= HRS_LATCH;
                        asyncMode_q <= ~rpdHigh;
                        latchCnt_q <= 3'h0;
                    end
                end
                HRS_LATCH: begin
                    // The synchroniser adds two cycles; they count toward the delay.
                    latchCnt_q <= latchCnt_q + 3'h1;
                    if (latchCnt_q == 3'((pllBypass ? LATCH_BYP_CLKS : LATCH_CLKS) - 3)) begin
                        state_q <= HRS_INIT;
                    end
                end
                default: begin
                    state_q <= HRS_RUN;
                end
            endcase
        end
    end

    // Low-pulse width counter, saturating; restarts whenever the input is high.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pulseCnt_q <= 11'h000;
        end else if (!rstLow) begin
            pulseCnt_q <= 11'h000;
        end else if (pulseCnt_q != 11'h7FF) begin
            pulseCnt_q <= pulseCnt_q + 11'h001;
        end
    end

    // Reset kind set at detection, marked long once the pulse reaches LONG_CLKS or the sequence extends, async flag updated at latch.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            kind <= '{longReset: 1'b0, shortReset: 1'b0, asyncReset: 1'b1};
        end else if (state_q == HRS_DETECT && seqCnt_q == 11'h000) begin
            kind <= '{longReset: 1'b0, shortReset: 1'b1, asyncReset: asyncMode_q};
        end else if (rstLow && !pullDown_q && pullEcho_q == 2'h0 &&
                     (pulseCnt_q >= 11'(LONG_CLKS) || state_q == HRS_EXTEND)) begin
            // A low level that only our own pull-down causes never counts as a press.
            kind.longReset <= 1'b1;
            kind.shortReset <= 1'b0;
        end else if (state_q == HRS_LATCH && latchCnt_q == 3'h0) begin
            kind.asyncReset <= asyncMode_q;
        end
    end

    // Enable bit: cleared at power-on and sequence end, set only during init.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bidirResetEnable <= 1'b0;
        end else if (state_q == HRS_LATCH) begin
            bidirResetEnable <= 1'b0;
        end else if (bidirEnableSet && state_q == HRS_INIT && !reset_out_n) begin
            // Once end-of-init has freed the reset output, requests are refused.
            bidirResetEnable <= 1'b1;
        end
    end

    // Pull-down is armed at detection from the enable bit and dropped when
    // the delay level falls or the timed sequence ends.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pullDown_q <= 1'b0;
        end else if (state_q != HRS_DETECT && state_q != HRS_SEQ) begin
            pullDown_q <= 1'b0;
        end else if (!rpdHigh) begin
            pullDown_q <= 1'b0;
        end else if (state_q == HRS_DETECT && seqCnt_q == 11'h000) begin
            pullDown_q <= bidirResetEnable;
        end else if (state_q == HRS_SEQ && seqCnt_q == 11'(SEQ_CLKS - 1)) begin
            pullDown_q <= 1'b0;
        end
    end
    // Follows the pull-down through the two synchroniser stages, so the pad
    // level sampled after release is the board's and not the echo of our own pull.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pullEcho_q <= 2'h0;
        end else begin
            pullEcho_q <= {pullEcho_q[0], pullDown_q};
        end
    end
    assign resetInOut = 1'b0;
    assign resetInOe = pullDown_q;

    // Core controls, reset output and configuration latch.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reset_out_n <= 1'b0;
            ctrl <= '{coreReset: 1'b1, cancelHold: 1'b1, abortBus: 1'b1,
                      tristateIo: 1'b1, pullConfigHigh: 1'b1, strobesIdle: 1'b0};
            latchedConfig <= '0;
            configValid <= 1'b0;
            startAddr <= `HRS_START_ADDR;
            startFetch <= 1'b0;
        end else begin
            startFetch <= 1'b0;
            if (state_q == HRS_DETECT || state_q == HRS_SEQ || state_q == HRS_EXTEND) begin
                reset_out_n <= 1'b0;
                ctrl.coreReset <= 1'b1;
                ctrl.cancelHold <= 1'b1;
                ctrl.abortBus <= 1'b1;
                ctrl.tristateIo <= 1'b1;
                ctrl.pullConfigHigh <= 1'b1;
                ctrl.strobesIdle <= 1'b0;
                configValid <= 1'b0;
            end else if (state_q == HRS_LATCH && state_q == HRS_LATCH &&
                         latchCnt_q == 3'((pllBypass ? LATCH_BYP_CLKS : LATCH_CLKS) - 3)) begin
                latchedConfig <= configPort;
                configValid <= 1'b1;
                ctrl.strobesIdle <= externalFetch;
                ctrl.pullConfigHigh <= 1'b0;
                ctrl.tristateIo <= 1'b0;
                ctrl.cancelHold <= 1'b0;
                ctrl.abortBus <= 1'b0;
                ctrl.coreReset <= 1'b0;
                startAddr <= `HRS_START_ADDR;
                startFetch <= 1'b1;
            end else if (state_q == HRS_INIT && endOfInitInstr) begin
                reset_out_n <= 1'b1;
            end
        end
    end

    // The raw entry path drives only unusedRaw and does not reach the core.
    logic unusedRaw; // Kept visible; nothing reads it.
    assign unusedRaw = rawEntry;
endmodule

// ==== test/hrs_monitor.sv ====
// Concurrent checks on the reset sequencer ports.
// Assumes one sys_clk domain and the synchronous reset_n.
`timescale 1ns/10ps
module hrs_monitor import hrs_pkg::*; (
    input wire logic sys_clk, // CPU clock.
    input wire logic reset_n, // Power-on reset.
    input wire logic resetInPin, // Pad level.
    input wire logic resetInOut, // Pad drive value.
    input wire logic resetInOe, // Pull-down enable.
    input wire logic powerdownDelayLevel, // Delay comparator.
    input wire logic pllBypass, // Short latch delay.
    input wire logic bidirEnableSet, // Enable bit request.
    input wire logic endOfInitInstr, // End-of-init pulse.
    input wire logic reset_out_n, // Reset output.
    input wire hrs_ctrl_t ctrl, // Core controls.
    input wire hrs_kind_t kind, // Reset kind.
    input wire logic bidirResetEnable, // Enable bit.
    input wire logic [23:0] startAddr, // Fetch address.
    input wire logic configValid, // Config latched.
    input wire logic startFetch // Execution start.
);
    logic [15:0] rstCnt_q; // Cycles with the core held in reset.
    logic [3:0] highCnt_q; // Cycles the pad has been high, saturating.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Counts reset length so a short sequence is visible at the fetch.
    always_ff @(posedge sys_clk) begin
        rstCnt_q <= (!reset_n || !ctrl.coreReset) ? 16'h0000 : rstCnt_q + 16'h0001;
    end
    // Saturates so a pad high for ages never wraps into a false short delay.
    always_ff @(posedge sys_clk) begin
        highCnt_q <= !resetInPin ? 4'h0 : ((highCnt_q == 4'hF) ? 4'hF : highCnt_q + 4'h1);
    end
    a_pin_forces_reset: assert property (!resetInPin [*3] |-> ##[0:8] (!reset_out_n && ctrl.coreReset && ctrl.pullConfigHigh)) else $error("pad low without reset state");
    a_sync_settles: assert property (!resetInPin [*3] |-> ##[0:8] (ctrl.tristateIo && ctrl.cancelHold && ctrl.abortBus)) else $error("bus not settled");
    a_drop_frees_pin: assert property (!powerdownDelayLevel [*4] |-> !resetInOe) else $error("pull-down kept with delay low");
    a_pull_needs_bit: assert property ($rose(resetInOe) |-> ($past(bidirResetEnable) || bidirResetEnable) && !resetInOut) else $error("pull-down without enable");
    a_seq_length: assert property (startFetch |-> rstCnt_q >= 16'h0200) else $error("sequence too short");
    a_latch_delay: assert property (startFetch |-> highCnt_q >= (pllBypass ? 4'h3 : 4'h4)) else $error("latch too early");
    a_fetch_at_zero: assert property (startFetch |-> startAddr == 24'h000000 && !bidirResetEnable && configValid) else $error("bad fetch start");
    a_out_till_init: assert property ($rose(reset_out_n) |-> $past(endOfInitInstr)) else $error("reset output freed early");
    a_set_only_init: assert property ($rose(bidirResetEnable) |-> $past(bidirEnableSet) && !$past(reset_out_n)) else $error("enable set outside init");
    c_short: cover property (startFetch && kind.shortReset);
    c_long: cover property (startFetch && kind.longReset);
    c_pull: cover property ($rose(resetInOe));
endmodule
bind hrs_top hrs_monitor u_hrs_monitor (.sys_clk(sys_clk), .reset_n(reset_n), .resetInPin(resetInPin),
    .resetInOut(resetInOut), .resetInOe(resetInOe), .powerdownDelayLevel(powerdownDelayLevel),
    .pllBypass(pllBypass), .bidirEnableSet(bidirEnableSet), .endOfInitInstr(endOfInitInstr),
    .reset_out_n(reset_out_n), .ctrl(ctrl), .kind(kind), .bidirResetEnable(bidirResetEnable),
    .startAddr(startAddr), .configValid(configValid), .startFetch(startFetch));

// ==== test/hrs_board.sv ====
// Board reset circuitry: pull-up on the reset pad, delay capacitor level.
// Assumes the bench calls its tasks; the pad is open drain with a pull-up.
`timescale 1ns/10ps
module hrs_board (
    input wire logic sys_clk, // CPU clock.
    input wire logic resetInOut, // Device pad value.
    input wire logic resetInOe, // Device pull-down enable.
    output logic resetInPin, // Resolved pad level.
    output logic powerdownDelayLevel // Delay comparator level.
);
    logic holdLow = 1'b1; // Board button, pressed at power-on.
    initial powerdownDelayLevel = 1'b0; // Capacitor empty at power-on.
    // Wired-AND of board and device; the pull-up wins only when both release.
    assign resetInPin = (holdLow || (resetInOe && !resetInOut)) ? 1'b0 : 1'b1;
    // Presses never go below two clocks, or the device may not see them.
    task automatic hold(input int n);
        int k;
        k = (n < 2) ? 2 : n;
        @(posedge sys_clk) holdLow <= 1'b1;
        repeat (k) @(posedge sys_clk);
        holdLow <= 1'b0;
    endtask
    // Moves the capacitor level across the threshold.
    task automatic set_delay(input logic lvl);
        @(posedge sys_clk) powerdownDelayLevel <= lvl;
    endtask
endmodule

// ==== test/hrs_top_tb.sv ====
// Self-checking bench for the reset sequencer with the board model.
// Assumes a 10 MHz sys_clk and the package types.
`timescale 1ns/10ps
module hrs_top_tb import hrs_pkg::*; ;
    logic sys_clk, reset_n, pllBypass, externalFetch, bidirEnableSet, endOfInitInstr;
    logic [15:0] configPort; // Start-up configuration.
    logic resetInPin, resetInOut, resetInOe, powerdownDelayLevel, reset_out_n;
    logic bidirResetEnable, configValid, startFetch;
    logic [15:0] latchedConfig;
    logic [23:0] startAddr;
    hrs_ctrl_t ctrl;
    hrs_kind_t kind;
    int err_total = 0;
    int checked = 0;
    hrs_top u_hrs_top (.sys_clk(sys_clk), .reset_n(reset_n), .resetInPin(resetInPin), .resetInOut(resetInOut),
        .resetInOe(resetInOe), .powerdownDelayLevel(powerdownDelayLevel), .configPort(configPort),
        .pllBypass(pllBypass), .externalFetch(externalFetch), .bidirEnableSet(bidirEnableSet),
        .endOfInitInstr(endOfInitInstr), .reset_out_n(reset_out_n), .ctrl(ctrl), .kind(kind),
        .bidirResetEnable(bidirResetEnable), .latchedConfig(latchedConfig), .configValid(configValid),
        .startAddr(startAddr), .startFetch(startFetch));
    hrs_board u_hrs_board (.sys_clk(sys_clk), .resetInOut(resetInOut), .resetInOe(resetInOe),
        .resetInPin(resetInPin), .powerdownDelayLevel(powerdownDelayLevel));
    always #50 sys_clk = ~sys_clk;
    // Compares with case equality so an unknown never passes.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Waits a bounded time for the fetch pulse, sampling after the edge settles.
    task automatic wait_fetch(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (startFetch !== 1'b1 && n < 2000);
        chk("startFetch", startFetch, 1);
        chk("startAddr", startAddr, 0);
    endtask
    // Optionally sets the enable bit, then ends initialisation.
    task automatic finish_init(input logic setBit);
        repeat (2) @(posedge sys_clk);
        bidirEnableSet <= setBit;
        @(posedge sys_clk);
        bidirEnableSet <= 1'b0;
        endOfInitInstr <= 1'b1;
        @(posedge sys_clk);
        endOfInitInstr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic power_on();
        int n;
        u_hrs_board.hold(3);
        wait_fetch(n);
        chk("kind", kind.asyncReset, 1);
        chk("config", latchedConfig, 16'hA5C3);
        chk("strobesIdle", ctrl.strobesIdle, 1);
        chk("outHeld", reset_out_n, 0);
        finish_init(1'b1);
        chk("bitSet", bidirResetEnable, 1);
        chk("outFree", reset_out_n, 1);
    endtask
    task automatic short_reset();
        int n;
        configPort <= 16'h1234;
        pllBypass <= 1'b1;
        u_hrs_board.set_delay(1'b1);
        u_hrs_board.hold(10);
        #1;
        chk("outLow", reset_out_n, 0);
        chk("tristate", ctrl.tristateIo, 1);
        chk("pullDown", resetInOe, 1);
        wait_fetch(n);
        chk("seqLen", (n >= 505 && n <= 520), 1);
        chk("kind", kind, 3'b010);
        chk("bitClear", bidirResetEnable, 0);
        chk("pullOff", resetInOe, 0);
        chk("config", latchedConfig, 16'h1234);
        finish_init(1'b0);
        finish_init(1'b1);
        chk("setRefused", bidirResetEnable, 0);
    endtask
    task automatic long_reset();
        int n;
        configPort <= 16'h5A0F;
        pllBypass <= 1'b0;
        externalFetch <= 1'b0;
        u_hrs_board.hold(600);
        wait_fetch(n);
        chk("latchDelay", (n >= 3 && n <= 6), 1);
        chk("kind", kind, 3'b100);
        chk("config", latchedConfig, 16'h5A0F);
        chk("strobesBusy", ctrl.strobesIdle, 0);
        finish_init(1'b1);
    endtask
    task automatic delay_drop();
        int n;
        u_hrs_board.hold(4);
        repeat (20) @(posedge sys_clk);
        #1;
        chk("pullDown", resetInOe, 1);
        u_hrs_board.set_delay(1'b0);
        repeat (6) @(posedge sys_clk);
        #1;
        chk("pullDropped", resetInOe, 0);
        wait_fetch(n);
        chk("asyncExit", kind.asyncReset, 1);
    endtask
    task automatic final_report();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        configPort = 16'hA5C3;
        pllBypass = 1'b0;
        externalFetch = 1'b1;
        bidirEnableSet = 1'b0;
        endOfInitInstr = 1'b0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        power_on();
        short_reset();
        long_reset();
        delay_drop();
        final_report();
    end
    // Four sequences need under 3000 cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        final_report();
    end
endmodule
